//--- logic/burst_sram_pkg.sv
// constants and types shared by the burst memory design
`default_nettype none
package burst_sram_pkg;
	localparam int DATA_W = 36;
	localparam int ADDR_W = 19;
	localparam int BYTE_W = 9;
	localparam int FIFO_DEPTH = 8;
	localparam int PIPE_DEPTH = 3;
	localparam int PLL_STAGE = 2;
	localparam int LEGACY_STAGE = 0;
	localparam int LEGACY_MAX_MHZ = 167;
	typedef enum logic {
		MODE_LEGACY,
		MODE_PLL
	} mode_t;
endpackage : burst_sram_pkg
`default_nettype wire

//--- logic/burst_sram.sv
// two-word burst memory with separate read and write ports
// Operation
// - inputs captured and read data launched on both input clock rises
// - echo clocks toggle continuously, following the positive input clock
// - pll_disable_n low selects legacy timing, input clock at most 167 MHz
// - read latency two and a half cycles with pll, one cycle without
// - accesses start and are recognised only at positive clock rises
// - each access moves two words of the port width in one cycle
// - write data registered on both clocks, read data through output registers
// - read, write and byte selects registered at clock rises before use
// - separate read output and write input ports sharing one address bus
// - with pll, first read word at negative rise t+2, second at positive rise t+3
// - write word0 with select at positive rise, address and word1 at negative rise
// - bytes with deasserted byte select stay unchanged in memory
// - read_data_valid rises half a cycle before data, aligned with echo clocks
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module burst_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] buf_q [DEPTH];
	logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [PW:0] cnt_q, cnt_d;
	logic push, pop;

	always_comb begin
		in_ready_o = cnt_q != (PW+1)'(DEPTH);
		out_valid_o = cnt_q != '0;
		out_data_o = buf_q[rp_q];
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		if (push) begin
			wp_d = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
		end
		if (pop) begin
			rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
		if (push) begin
			buf_q[wp_q] <= in_data_i;
		end
	end
endmodule : burst_fifo

////////////////////////////////////////////////////////////////////////////////
module burst_sram
	import burst_sram_pkg::*;
#(
	parameter int DW = DATA_W,
	parameter int AW = ADDR_W,
	parameter int FD = FIFO_DEPTH
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic k_i,
	input wire logic k_n_i,
	input wire logic pll_disable_n_i,
	input wire logic read_select_n_i,
	input wire logic write_select_n_i,
	input wire logic [DW/BYTE_W-1:0] byte_write_select_n_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	output logic [DW-1:0] rdata_o,
	output logic rdata_oe_n_o,
	output logic read_data_valid_o,
	output logic echo_clock_out_o,
	output logic echo_clock_out_n_o
);
	localparam int NB = DW / BYTE_W;
	localparam int EW = AW + 2 * DW + 2 * NB;
	localparam int SW = 5 + NB + AW + DW;

	function automatic logic [DW-1:0] merge_bytes(input logic [DW-1:0] old_w, input logic [DW-1:0] new_w,
		input logic [NB-1:0] be);
		logic [DW-1:0] res;
		res = old_w;
		for (int b = 0; b < NB; b++) begin
			if (be[b]) begin
				res[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
			end
		end
		return res;
	endfunction : merge_bytes

	////////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for every pin
	logic [SW-1:0] pin_raw, sy1_q, sy2_q;
	logic k_s, kn_s, pll_s, rsel_n_s, wsel_n_s;
	logic [NB-1:0] bws_n_s;
	logic [AW-1:0] addr_s;
	logic [DW-1:0] wdata_s;
	logic k_old_q, kn_old_q, k_rise, kn_rise;

	always_comb begin
		pin_raw = {k_i, k_n_i, pll_disable_n_i, read_select_n_i, write_select_n_i, byte_write_select_n_i,
			addr_i, wdata_i};
		{k_s, kn_s, pll_s, rsel_n_s, wsel_n_s, bws_n_s, addr_s, wdata_s} = sy2_q;
		k_rise = k_s && !k_old_q;
		kn_rise = kn_s && !kn_old_q;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sy1_q <= '0;
			sy2_q <= '0;
			k_old_q <= 1'b0;
			kn_old_q <= 1'b0;
		end else begin
			sy1_q <= pin_raw;
			sy2_q <= sy1_q;
			k_old_q <= k_s;
			kn_old_q <= kn_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write capture: word0 at k rise, address and word1 at k_n rise
	logic wr_pend_q, wr_pend_d;
	logic [DW-1:0] wd0_q, wd0_d;
	logic [NB-1:0] be0_q, be0_d;
	logic wr_push, wr_ready, drn_valid, drn_ready;
	logic [EW-1:0] wr_entry, drn_entry;
	logic [AW-1:0] drn_addr;
	logic [DW-1:0] drn_w0, drn_w1;
	logic [NB-1:0] drn_be0, drn_be1;
	logic [2*DW-1:0] mem_q [2**AW];

	always_comb begin
		wr_pend_d = wr_pend_q;
		wd0_d = wd0_q;
		be0_d = be0_q;
		wr_push = 1'b0;
		if (k_rise) begin
			wr_pend_d = !wsel_n_s;
			wd0_d = wdata_s;
			be0_d = ~bws_n_s;
		end else if (kn_rise && wr_pend_q) begin
			wr_push = wr_ready;
			wr_pend_d = 1'b0;
		end
		wr_entry = {addr_s, wd0_q, wdata_s, be0_q, ~bws_n_s};
		drn_ready = !k_rise;
		{drn_addr, drn_w0, drn_w1, drn_be0, drn_be1} = drn_entry;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wr_pend_q <= 1'b0;
			wd0_q <= '0;
			be0_q <= '0;
		end else begin
			wr_pend_q <= wr_pend_d;
			wd0_q <= wd0_d;
			be0_q <= be0_d;
		end
		if (drn_valid && drn_ready) begin
			mem_q[drn_addr] <= {merge_bytes(mem_q[drn_addr][2*DW-1:DW], drn_w1, drn_be1),
				merge_bytes(mem_q[drn_addr][DW-1:0], drn_w0, drn_be0)};
		end
	end

	burst_fifo #(.WIDTH(EW), .DEPTH(FD)) wr_fifo (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.in_valid_i(wr_push),
		.in_ready_o(wr_ready),
		.in_data_i(wr_entry),
		.out_valid_o(drn_valid),
		.out_ready_i(drn_ready),
		.out_data_o(drn_entry)
	);

	////////////////////////////////////////////////////////////////////////////
	// read pipeline, one stage per k rise
	mode_t mode_q, mode_d;
	logic st_v_q [PIPE_DEPTH];
	logic st_v_d [PIPE_DEPTH];
	logic [2*DW-1:0] st_w_q [PIPE_DEPTH];
	logic [2*DW-1:0] st_w_d [PIPE_DEPTH];
	logic w0_edge, w1_edge, launch0, launch1, next0;
	logic [DW-1:0] out_w0, out_w1;

	always_comb begin
		mode_d = mode_q;
		for (int s = 0; s < PIPE_DEPTH; s++) begin
			st_v_d[s] = st_v_q[s];
			st_w_d[s] = st_w_q[s];
		end
		if (k_rise) begin
			mode_d = pll_s ? MODE_PLL : MODE_LEGACY;
			st_v_d[0] = !rsel_n_s;
			st_w_d[0] = mem_q[addr_s];
			for (int s = 1; s < PIPE_DEPTH; s++) begin
				st_v_d[s] = st_v_q[s-1];
				st_w_d[s] = st_w_q[s-1];
			end
		end
		if (mode_q == MODE_PLL) begin
			w0_edge = kn_rise;
			w1_edge = k_rise;
			launch0 = st_v_q[PLL_STAGE];
			launch1 = st_v_q[PLL_STAGE];
			next0 = st_v_q[PLL_STAGE-1];
			out_w0 = st_w_q[PLL_STAGE][DW-1:0];
			out_w1 = st_w_q[PLL_STAGE][2*DW-1:DW];
		end else begin
			w0_edge = k_rise;
			w1_edge = kn_rise;
			launch0 = st_v_q[LEGACY_STAGE];
			launch1 = st_v_q[LEGACY_STAGE+1];
			next0 = st_v_q[LEGACY_STAGE];
			out_w0 = st_w_q[LEGACY_STAGE][DW-1:0];
			out_w1 = st_w_q[LEGACY_STAGE+1][2*DW-1:DW];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			mode_q <= MODE_PLL;
			for (int s = 0; s < PIPE_DEPTH; s++) begin
				st_v_q[s] <= 1'b0;
				st_w_q[s] <= '0;
			end
		end else begin
			mode_q <= mode_d;
			for (int s = 0; s < PIPE_DEPTH; s++) begin
				st_v_q[s] <= st_v_d[s];
				st_w_q[s] <= st_w_d[s];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output registers, echo clocks and valid
	logic [DW-1:0] rdata_q, rdata_d;
	logic oe_n_q, oe_n_d, vld_q, vld_d, echo_q, echo_d, echo_n_q, echo_n_d;

	always_comb begin
		rdata_d = rdata_q;
		oe_n_d = oe_n_q;
		vld_d = vld_q;
		echo_d = k_s;
		echo_n_d = !k_s;
		if (w0_edge) begin
			oe_n_d = !launch0;
			if (launch0) begin
				rdata_d = out_w0;
			end
		end
		if (w1_edge) begin
			vld_d = next0;
			if (launch1) begin
				rdata_d = out_w1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rdata_q <= '0;
			oe_n_q <= 1'b1;
			vld_q <= 1'b0;
			echo_q <= 1'b0;
			echo_n_q <= 1'b1;
		end else begin
			rdata_q <= rdata_d;
			oe_n_q <= oe_n_d;
			vld_q <= vld_d;
			echo_q <= echo_d;
			echo_n_q <= echo_n_d;
		end
	end

	always_comb begin
		rdata_o = rdata_q;
		rdata_oe_n_o = oe_n_q;
		read_data_valid_o = vld_q;
		echo_clock_out_o = echo_q;
		echo_clock_out_n_o = echo_n_q;
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	echo_follow_a: assert property (k_rise |=> echo_clock_out_o && !echo_clock_out_n_o)
		else $error("echo clock missed a k rise");
	echo_low_a: assert property ($rose(kn_s) && !k_s |=> !echo_clock_out_o)
		else $error("echo clock stayed high in k low phase");
	read_take_a: assert property (k_rise && !rsel_n_s |=> st_v_q[0])
		else $error("read request not taken at k rise");
	pll_word0_a: assert property (mode_q == MODE_PLL && kn_rise && st_v_q[PLL_STAGE] && !k_rise
		|=> !rdata_oe_n_o && rdata_o == $past(st_w_q[PLL_STAGE][DW-1:0]))
		else $error("first read word not launched at k_n rise");
	pll_word1_a: assert property (mode_q == MODE_PLL && k_rise && st_v_q[PLL_STAGE]
		|=> rdata_o == $past(st_w_q[PLL_STAGE][2*DW-1:DW]))
		else $error("second read word not launched at k rise");
	legacy_word0_a: assert property (mode_q == MODE_LEGACY && k_rise && st_v_q[LEGACY_STAGE] && !kn_rise
		|=> !rdata_oe_n_o && rdata_o == $past(st_w_q[LEGACY_STAGE][DW-1:0]))
		else $error("legacy read word not one cycle after request");
	valid_lead_a: assert property ($rose(read_data_valid_o) |-> rdata_oe_n_o ##[1:12] $fell(rdata_oe_n_o))
		else $error("valid not followed by read data");
	data_edges_a: assert property ($changed(rdata_o) |-> $past(k_rise || kn_rise))
		else $error("read data changed off a clock rise");
	write_push_a: assert property (wr_push |-> kn_rise && wr_pend_q)
		else $error("write stored outside a k_n rise");
endmodule : burst_sram
`default_nettype wire

//--- tb/host_model.sv
// host controller model: link clocks and request pins
`default_nettype none
module host_model (
	input wire logic mclk_i,
	input wire logic [2:0] phase_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [5:0] raddr_i,
	input wire logic [5:0] waddr_i,
	input wire logic [71:0] wline_i,
	input wire logic [7:0] be_n_i,
	input wire logic [31:0] noise_i,
	output logic k_o,
	output logic k_n_o,
	output logic read_select_n_o,
	output logic write_select_n_o,
	output logic [3:0] byte_write_select_n_o,
	output logic [5:0] addr_o,
	output logic [35:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{k_o, k_n_o, read_select_n_o, write_select_n_o} = 4'h7;
		{byte_write_select_n_o, addr_o, wdata_o} = {4'hF, 6'h00, 36'h0};
	end
	////////////////////////////////////////////////////////////////////////////
	always @(negedge mclk_i) begin
		k_o <= (phase_i < 3'h4);
		k_n_o <= (phase_i >= 3'h4);
		if (phase_i == 3'h6) begin
			read_select_n_o <= rd_n_i;
			write_select_n_o <= wr_n_i;
			addr_o <= raddr_i;
			wdata_o <= wline_i[35:0];
			byte_write_select_n_o <= be_n_i[3:0];
		end else if (phase_i == 3'h2) begin
			read_select_n_o <= noise_i[0];
			write_select_n_o <= noise_i[1];
			addr_o <= waddr_i;
			wdata_o <= wline_i[71:36];
			byte_write_select_n_o <= be_n_i[7:4];
		end
	end
endmodule : host_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the burst memory
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic pll_n = 1'h1;
	logic rd_n = 1'h1;
	logic wr_n = 1'h1;
	logic [5:0] raddr = 6'h00;
	logic [5:0] waddr = 6'h00;
	logic [71:0] wline = 72'h0;
	logic [7:0] be_n = 8'hFF;
	logic [31:0] seed = 32'hA2B0;
	logic [35:0] last_w1 = 36'h0;
	wire logic k, k_n, rs_n, ws_n, oe_n, vld, eck, eck_n;
	wire logic [3:0] bws_n;
	wire logic [5:0] addr;
	wire logic [35:0] wdata, rdata;
	int n = 0;
	int miscompares = 0;
	int check_count = 0;
	logic [71:0] mem [64];
	logic [36:0] exp_d [int];
	always #25 mclk = ~mclk;
	host_model host_model_i (.mclk_i(mclk), .phase_i(n[2:0]), .rd_n_i(rd_n), .wr_n_i(wr_n), .raddr_i(raddr),
		.waddr_i(waddr), .wline_i(wline), .be_n_i(be_n), .noise_i(seed), .k_o(k), .k_n_o(k_n),
		.read_select_n_o(rs_n), .write_select_n_o(ws_n), .byte_write_select_n_o(bws_n), .addr_o(addr),
		.wdata_o(wdata));
	burst_sram #(.AW(6)) burst_sram_i (.mclk_i(mclk), .rst_i(rst), .k_i(k), .k_n_i(k_n),
		.pll_disable_n_i(pll_n), .read_select_n_i(rs_n), .write_select_n_i(ws_n),
		.byte_write_select_n_i(bws_n), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rdata_oe_n_o(oe_n),
		.read_data_valid_o(vld), .echo_clock_out_o(eck), .echo_clock_out_n_o(eck_n));
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	task automatic step(input bit rd, input bit wr, input logic [5:0] ra, input logic [5:0] wa, input logic [7:0] be);
		int c;
		do @(negedge mclk); while (n % 8 != 5);
		c = n / 8 + 1;
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			wline = {wline[47:0], seed[23:0]};
		end
		{rd_n, wr_n, raddr, waddr, be_n} = {~rd, ~wr, ra, wa, ~be};
		if (rd && pll_n) begin
			exp_d[(c + 3) * 8 + 2] = {1'h1, mem[ra][35:0]};
			exp_d[(c + 3) * 8 + 6] = {1'h0, mem[ra][71:36]};
		end else if (rd) begin
			exp_d[(c + 1) * 8 + 6] = {1'h1, mem[ra][35:0]};
			exp_d[(c + 2) * 8 + 2] = {1'h0, mem[ra][71:36]};
		end
		if (rd)
			last_w1 = mem[ra][71:36];
		for (int b = 0; b < 8; b++)
			if (wr && be[b])
				mem[wa][b * 9 +: 9] = wline[b * 9 +: 9];
	endtask : step
	task automatic run(input int cnt, input bit mode);
		repeat (6) step(0, 0, 6'h00, 6'h00, 8'h00);
		pll_n = mode;
		for (int i = 0; i < cnt; i++) begin
			seed = xs(seed);
			step(seed[0] | seed[1], seed[2] | seed[3], seed[9:4], seed[15:10], seed[23:16]);
		end
	endtask : run
	////////////////////////////////////////////////////////////////////////////
	always @(negedge mclk) begin
		n <= n + 1;
		if (exp_d.exists(n)) begin
			check("rdata", rdata, exp_d[n][35:0]);
			check("oe_n", {35'h0, oe_n}, 36'h0);
			if (exp_d[n][36])
				check("valid", {35'h0, vld}, 36'h1);
			exp_d.delete(n);
		end
		if (n > 40 && n % 4 == 2)
			check("echo", {34'h0, eck, eck_n}, {34'h0, n % 8 == 6, n % 8 != 6});
	end
	initial begin
		repeat (8) @(negedge mclk);
		rst = 1'h0;
		for (int a = 0; a < 64; a++)
			step(0, 1, 6'h00, a[5:0], 8'hFF);
		$display("test fill done");
		run(150, 1'h1);
		$display("test pll done");
		run(150, 1'h0);
		$display("test legacy done");
		for (int a = 0; a < 8; a++) begin
			seed = xs(seed);
			step(1'h1, 1'h1, a[5:0], 6'(a + 1), seed[7:0]);
		end
		$display("test fifo done");
		repeat (6) step(0, 0, 6'h00, 6'h00, 8'h00);
		check("pending", 36'(exp_d.size()), 36'h0);
		check("idle oe_n", {35'h0, oe_n}, 36'h1);
		check("idle valid", {35'h0, vld}, 36'h0);
		check("idle data", rdata, last_w1);
		finish_test();
	end
	initial begin
		repeat (8000) @(posedge mclk);
		miscompares++;
		finish_test();
	end
endmodule : testbench
`default_nettype wire
